// ---- xpd_map.vh ----
`ifndef XPD_MAP_VH
`define XPD_MAP_VH

// Register byte offsets on the APB slave.
`define XPD_OFS_PERIPH_ENABLE 8'h00
`define XPD_OFS_ENABLE_MIRROR 8'h04
`define XPD_OFS_EMU_REG0      8'h08
`define XPD_OFS_EMU_REG3      8'h14
`define XPD_OFS_SYSTEM_CONFIG 8'h18
`define XPD_OFS_THIRD_RANGE   8'h1C
`define XPD_OFS_STATUS        8'h20

// Enable register bit positions.
`define XPD_BIT_FIRST_CAN     0
`define XPD_BIT_SECOND_CAN    1
`define XPD_BIT_SMALL_RAM     2
`define XPD_BIT_LARGE_RAM     3
`define XPD_BIT_RTC           4
`define XPD_BIT_PWM           6
`define XPD_BIT_ASYNC_SERIAL  7
`define XPD_BIT_SYNC_SERIAL   8
`define XPD_BIT_I2C           9
`define XPD_BIT_MISC          10

// Bits that may be stored, reset value and read value in emulation mode.
`define XPD_ENABLE_WMASK      16'h07DF
`define XPD_ENABLE_RESET      16'h0005
`define XPD_ENABLE_EMU_READ   16'hFFFF
// Extension peripherals that count for the shared window (no memories).
`define XPD_PERIPH_MASK       16'h07D3
// Peripherals whose enable blocks port 1 addressing.
`define XPD_PORT1_MASK        16'h03C0

// System configuration: global extension enable bit.
`define XPD_BIT_GLOBAL_EN     2
`define XPD_SYSCFG_RESET      16'h0000

// Third dedicated range: reset value and largest size code.
`define XPD_RANGE_RESET       16'h800B
`define XPD_RGSZ_MAX          4'hB

// Address windows (24-bit byte addresses).
`define XPD_WIN_SHARED_LO     24'h00E800
`define XPD_WIN_SHARED_HI     24'h00EFFF
`define XPD_WIN_SMALL_RAM_LO  24'h00E000
`define XPD_WIN_SMALL_RAM_HI  24'h00E7FF
`define XPD_BASE_SYNC_SERIAL  8'hE8
`define XPD_BASE_ASYNC_SERIAL 8'hE9
`define XPD_BASE_I2C          8'hEA
`define XPD_BASE_MISC         8'hEB
`define XPD_BASE_PWM          8'hEC
`define XPD_BASE_RTC          8'hED
`define XPD_BASE_SECOND_CAN   8'hEE
`define XPD_BASE_FIRST_CAN    8'hEF

`endif

// ---- xpd_periph_enable.v ----
// Operation
// - Bit 6 gates PWM window EC00-ECFF.
// - Bit 4 gates RTC window ED00-EDFF.
// - Bit 3 off sends large RAM external.
// - Bit 2 off sends E000-E7FF external always.
// - Bit 1 gates second CAN, frees pins.
// - Bit 0 gates first CAN, frees pins.
// - All peripherals off: E800-EFFF goes external.
// - Disabled peripheral pins become general I/O.
// - Serial, I2C or PWM on blocks port 1.
// - Reset enables first CAN and small RAM.
// - Global enable set locks the enable register.
// - Emulation mode reads all enable bits set.
// - Mirror register has identical bit layout.
// - Four more emulation registers, write only.
// - Large RAM select needs global and bit 3.
// - Large RAM uses its own range decode.
// - Third range register resets, not locked by global enable.
// - Bits 10..7 gate misc, I2C, sync, async serial.
// - After end of init, gate unused peripheral clocks except misc.
// - Third range writable only before end of init.
`timescale 1ns/1ps
`include "xpd_map.vh"

module xpd_periph_enable #(
    parameter ADDR_W = 24
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [7:0]        paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output reg  [31:0]       prdata,
    output reg               pslverr,
    input  wire              emu_mode_pin,
    input  wire              end_of_init_instruction,
    input  wire              cpu_req,
    input  wire [ADDR_W-1:0] cpu_addr,
    output reg  [10:0]       unit_sel,
    output reg               small_ram_sel,
    output reg               large_ram_cs,
    output reg               ext_mem_sel,
    output reg  [10:0]       pins_gpio,
    output reg               port1_addr_inhibit,
    output reg  [10:0]       unit_clk_en,
    output reg  [15:0]       mirror_value,
    output reg  [63:0]       emu_regs_flat
);

    // Register map, one aligned word each:
    // 0x00 enable bits, read as decoded.
    // 0x04 emulation mirror, reads zero.
    // 0x08 to 0x14 emulation words, write only.
    // 0x18 system word with the global enable.
    // 0x1C large RAM range select.
    // 0x20 read-only status flags.

    // Registers written by software.
    reg  [15:0] internal_peripheral_bus_peripheral_enable;        // Live enable bits.
    reg  [15:0] internal_peripheral_bus_peripheral_enable_mirror; // Copy for emulation hardware.
    reg  [15:0] emu_reg [0:3];                 // Write-only emulation registers.
    reg  [15:0] system_configuration;          // Holds the global enable bit.
    reg  [15:0] third_dedicated_range;         // Large RAM range select.
    reg         init_done;                     // Set once end of init has run.

    // Emulation strap synchroniser; the first stage feeds only the second.
    reg         emu_meta;
    reg         emu_mode;

    // Decode terms.
    wire        global_en;                     // Global extension enable.
    wire [15:0] enable_view;                   // Enable value as software sees it.
    wire [15:0] active;                        // Enable bits qualified by global enable.
    wire        any_periph;                    // Some non-memory peripheral is on.
    wire        apb_setup;                     // Setup phase of an APB transfer.
    wire        apb_write;                     // Write commits in the access phase.
    wire [10:0] unit_hit;                      // Address hits an enabled unit window.
    wire        shared_hit;                    // Address inside E800-EFFF.
    wire        small_hit;                     // Address inside the small RAM window.
    wire        large_hit;                     // Address inside the large RAM range.

    // Maps an enable bit to its unit's page;
    // bits without a page are never called.

    // Returns the high address byte of each unit window by bit index.
    function [7:0] unit_base;
        input integer idx;
        begin
            case (idx)
                `XPD_BIT_FIRST_CAN:    unit_base = `XPD_BASE_FIRST_CAN;
                `XPD_BIT_SECOND_CAN:   unit_base = `XPD_BASE_SECOND_CAN;
                `XPD_BIT_RTC:          unit_base = `XPD_BASE_RTC;
                `XPD_BIT_PWM:          unit_base = `XPD_BASE_PWM;
                `XPD_BIT_ASYNC_SERIAL: unit_base = `XPD_BASE_ASYNC_SERIAL;
                `XPD_BIT_SYNC_SERIAL:  unit_base = `XPD_BASE_SYNC_SERIAL;
                `XPD_BIT_I2C:          unit_base = `XPD_BASE_I2C;
                `XPD_BIT_MISC:         unit_base = `XPD_BASE_MISC;
                default:               unit_base = 8'h00;
            endcase
        end
    endfunction

    // Both ends of a window are inclusive.

    // True when an address lies inside an inclusive window.
    function in_window;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] lo;
        input [ADDR_W-1:0] hi;
        begin
            in_window = (addr >= lo) && (addr <= hi);
        end
    endfunction

    // Size code n spans 256 bytes shifted by n.
    // Start bits below the size are ignored.
    // Codes above the largest size never match,
    // so a reserved value is harmless.
    // The loop unrolls into plain comparators.

    // Range select match: start bits above the size are compared, A23-A20 must be zero.
    function range_match;
        input [ADDR_W-1:0] addr;
        input [15:0]       rng;
        integer            k;
        reg                ok;
        begin
            ok = (addr[23:20] == 4'h0) && (rng[3:0] <= `XPD_RGSZ_MAX);
            for (k = 0; k < 12; k = k + 1) begin
                if ((k >= rng[3:0]) && (addr[8+k] != rng[4+k])) begin
                    ok = 1'b0;
                end
            end
            range_match = ok;
        end
    endfunction

    // The strap is static in practice, so the
    // two cycles of latency cost nothing.

    // The emulation strap comes from a pin, so it is synchronised before use.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emu_meta <= 1'b0;
            emu_mode <= 1'b0;
        end else begin
            emu_meta <= emu_mode_pin;
            emu_mode <= emu_meta;
        end
    end

    // Decode terms shared by every path below.

    assign global_en   = system_configuration[`XPD_BIT_GLOBAL_EN];
    // In emulation every unit counts as enabled.
    assign enable_view = emu_mode ? `XPD_ENABLE_EMU_READ : internal_peripheral_bus_peripheral_enable;
    // A unit is only live once the global enable is set as well.
    assign active      = global_en ? enable_view : 16'h0000;
    assign any_periph  = |(active & `XPD_PERIPH_MASK);

    // The slave never stretches a transfer.

    // Zero-wait slave: the read value is captured in the setup phase.
    assign pready    = 1'b1;
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;

    // Only a reset, clearing the global enable or
    // a change of emulation mode changes the set of units once it is set.
    // The range register locks at end of init.

    // Software register writes with the locks that guard them.
    always @(posedge pclk or negedge presetn) begin : reg_write
        integer i;
        if (!presetn) begin
            internal_peripheral_bus_peripheral_enable        <= `XPD_ENABLE_RESET;
            internal_peripheral_bus_peripheral_enable_mirror <= `XPD_ENABLE_RESET;
            system_configuration          <= `XPD_SYSCFG_RESET;
            third_dedicated_range         <= `XPD_RANGE_RESET;
            for (i = 0; i < 4; i = i + 1) begin
                emu_reg[i] <= 16'h0000;
            end
        end else if (apb_write) begin
            case (paddr)
                `XPD_OFS_PERIPH_ENABLE: begin
                    // Frozen once the global enable is set; reserved bits never stored.
                    if (!global_en) begin
                        internal_peripheral_bus_peripheral_enable <= pwdata[15:0] & `XPD_ENABLE_WMASK;
                    end
                end
                `XPD_OFS_ENABLE_MIRROR: begin
                    // Same layout as the enable register, so the same mask applies.
                    internal_peripheral_bus_peripheral_enable_mirror <= pwdata[15:0] & `XPD_ENABLE_WMASK;
                end
                `XPD_OFS_SYSTEM_CONFIG: begin
                    system_configuration <= pwdata[15:0];
                end
                `XPD_OFS_THIRD_RANGE: begin
                    // Protected: after end of init the range is fixed.
                    if (!init_done) begin
                        third_dedicated_range <= pwdata[15:0];
                    end
                end
                default: begin
                    // Emulation registers take one word each, write only.
                    if ((paddr >= `XPD_OFS_EMU_REG0) && (paddr <= `XPD_OFS_EMU_REG3)
                        && (paddr[1:0] == 2'b00)) begin
                        emu_reg[paddr[3:2] - 2'd2] <= pwdata[15:0];
                    end
                end
            endcase
        end
    end

    // The strobe comes from core logic on this
    // clock, so it needs no synchroniser.

    // End of init is a one-way latch; only reset brings it back.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_done <= 1'b0;
        end else if (end_of_init_instruction) begin
            init_done <= 1'b1;
        end
    end

    // Setup capture keeps the mux off the access
    // edge; a write commits before the next
    // setup, so write then read sees new data.
    // Bad offsets give zero data and an error.

    // Read data and error flag are captured in the setup phase and held for access.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (pwrite) begin
                // Writes to unmapped offsets and the status word are flagged, others accepted.
                pslverr <= (paddr > `XPD_OFS_THIRD_RANGE) || (paddr[1:0] != 2'b00);
            end else begin
                case (paddr)
                    `XPD_OFS_PERIPH_ENABLE: prdata <= {16'h0000, enable_view};
                    // Mirror and emulation registers read as zero.
                    `XPD_OFS_ENABLE_MIRROR: prdata <= 32'h00000000;
                    `XPD_OFS_SYSTEM_CONFIG: prdata <= {16'h0000, system_configuration};
                    `XPD_OFS_THIRD_RANGE:   prdata <= {16'h0000, third_dedicated_range};
                    `XPD_OFS_STATUS:        prdata <= {29'h00000000, emu_mode, port1_addr_inhibit, init_done};
                    default: begin
                        // Emulation registers are mapped but unreadable; all else is an error.
                        pslverr <= !((paddr >= `XPD_OFS_EMU_REG0) && (paddr <= `XPD_OFS_EMU_REG3)
                                     && (paddr[1:0] == 2'b00));
                    end
                endcase
            end
        end
    end

    // Each unit owns one 256-byte page in the
    // shared block; the top byte must be zero so
    // aliases in other segments never hit.
    // A unit hits only while it is active.
    // RAMs decode below; bit 5 has no unit.

    // Window hits for every unit that has its own 256-byte window.
    genvar g;
    generate
        for (g = 0; g < 11; g = g + 1) begin : g_unit
            if ((g == `XPD_BIT_SMALL_RAM) || (g == `XPD_BIT_LARGE_RAM) || (g == 5)) begin : g_none
                // Memories decode elsewhere and bit 5 has no unit.
                assign unit_hit[g] = 1'b0;
            end else begin : g_win
                assign unit_hit[g] = active[g] && (cpu_addr[ADDR_W-1:16] == 8'h00)
                                     && (cpu_addr[15:8] == unit_base(g));
            end
        end
    endgenerate

    // A large range over a unit page is a
    // software fault: both selects then rise.

    assign shared_hit = in_window(cpu_addr, `XPD_WIN_SHARED_LO, `XPD_WIN_SHARED_HI);
    assign small_hit  = in_window(cpu_addr, `XPD_WIN_SMALL_RAM_LO, `XPD_WIN_SMALL_RAM_HI);
    // The large RAM range comes from its own register, never the general chip selects.
    assign large_hit  = range_match(cpu_addr, third_dedicated_range);

    // Priority, highest first: an active unit
    // page; the shared block, external only when
    // no unit is active; the small RAM window;
    // the large RAM range; all else external.
    // Selects are registered, so they follow the
    // address by one cycle; a cycle without a
    // request clears them so no target sees a
    // stale strobe.

    // Access steering, registered one cycle after the request.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_sel      <= 11'h000;
            small_ram_sel <= 1'b0;
            large_ram_cs  <= 1'b0;
            ext_mem_sel   <= 1'b0;
        end else if (cpu_req) begin
            unit_sel      <= unit_hit;
            small_ram_sel <= small_hit && active[`XPD_BIT_SMALL_RAM];
            large_ram_cs  <= large_hit && global_en && enable_view[`XPD_BIT_LARGE_RAM];
            if (|unit_hit) begin
                // An enabled on-chip unit always claims its own address.
                ext_mem_sel <= 1'b0;
            end else if (shared_hit) begin
                // The shared window leaves the chip only when no unit is on at all.
                ext_mem_sel <= !any_periph;
            end else if (small_hit) begin
                ext_mem_sel <= !active[`XPD_BIT_SMALL_RAM];
            end else if (large_hit) begin
                // A disabled large RAM turns its range into plain external memory.
                ext_mem_sel <= !(global_en && enable_view[`XPD_BIT_LARGE_RAM]);
            end else begin
                ext_mem_sel <= 1'b1;
            end
        end else begin
            unit_sel      <= 11'h000;
            small_ram_sel <= 1'b0;
            large_ram_cs  <= 1'b0;
            ext_mem_sel   <= 1'b0;
        end
    end

    // These follow the enables every cycle.
    // Clocks stay on until end of init so that
    // software can still set up every unit;
    // gating is final only after that point.

    // Pin release, port 1 inhibit and clock gating follow the live enables.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_gpio          <= 11'h7FF;
            port1_addr_inhibit <= 1'b0;
            unit_clk_en        <= 11'h7FF;
        end else begin
            // A pin of a unit that is not enabled is free for general I/O.
            pins_gpio          <= ~active[10:0];
            // Serial, I2C and PWM units borrow port 1, so demultiplexed mode is lost.
            port1_addr_inhibit <= |(active & `XPD_PORT1_MASK);
            // Clocks run until end of init; after it only enabled units keep them.
            // RAMs and the misc block are never gated since software relies on them.
            unit_clk_en        <= {1'b1, active[9:4], 2'b11, active[1:0]}
                                  | {11{!init_done}};
        end
    end

    // Registered copies never change mid-cycle
    // on the emulation side.

    // Mirror and emulation registers go straight to the emulation hardware.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mirror_value  <= 16'h0000;
            emu_regs_flat <= 64'h0000000000000000;
        end else begin
            mirror_value  <= internal_peripheral_bus_peripheral_enable_mirror;
            emu_regs_flat <= {emu_reg[3], emu_reg[2], emu_reg[1], emu_reg[0]};
        end
    end

endmodule // xpd_periph_enable

// ---- xpd_cpu_model.sv ----
`timescale 1ns/1ps
// Core side of the decode path: one address per request, then it lets go.
module xpd_cpu_model #(
    parameter ADDR_W = 24
) (
    input  wire              pclk,
    output reg               cpu_req,
    output reg  [ADDR_W-1:0] cpu_addr
);
    // Idle from time zero so the decoder never sees an unknown request.
    initial begin
        cpu_req  = 1'b0;
        cpu_addr = {ADDR_W{1'b0}};
    end

    // One access cycle; a released address shows its inverse so stale values never pass.
    task access(input [ADDR_W-1:0] a);
        begin
            @(posedge pclk);
            cpu_req  <= 1'b1;
            cpu_addr <= a;
            @(posedge pclk);
            cpu_req  <= 1'b0;
            cpu_addr <= ~a;
        end
    endtask
endmodule // xpd_cpu_model

// ---- xpd_periph_enable_monitor.sv ----
`timescale 1ns/1ps
// Watches the decode outputs against the address that caused them.
module xpd_monitor #(
    parameter ADDR_W = 24
) (
    input wire              pclk,
    input wire              presetn,
    input wire              psel,
    input wire              penable,
    input wire              pready,
    input wire              cpu_req,
    input wire [ADDR_W-1:0] cpu_addr,
    input wire [10:0]       unit_sel,
    input wire              small_ram_sel,
    input wire              large_ram_cs,
    input wire              ext_mem_sel,
    input wire [10:0]       pins_gpio,
    input wire              port1_addr_inhibit,
    input wire [10:0]       unit_clk_en
);
    reg [ADDR_W-9:0] prev_page; // Page of the previous cycle's address.

    // Selects lag the request by one cycle, so the page is kept one cycle too.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_page <= {(ADDR_W-8){1'b0}};
        end else begin
            prev_page <= cpu_addr[ADDR_W-1:8];
        end
    end

    // Everything runs on the bus clock and is quiet in reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_zero_wait:
        assert property (psel && penable |-> pready) else $error("pready low in access phase");
    a_idle_quiet:
        assert property (!cpu_req |=> unit_sel == 11'h000 && !small_ram_sel && !large_ram_cs && !ext_mem_sel)
        else $error("select raised without a request");
    a_pwm_window:
        assert property (unit_sel[6] |-> prev_page == 16'h00EC) else $error("pwm selected off its window");
    a_rtc_window:
        assert property (unit_sel[4] |-> prev_page == 16'h00ED) else $error("rtc selected off its window");
    a_small_window:
        assert property (small_ram_sel |-> prev_page[15:3] == 13'h001C) else $error("small ram off window");
    a_large_needs_en:
        assert property (large_ram_cs |-> !pins_gpio[3]) else $error("large ram select while disabled");
    a_shared_external:
        assert property (ext_mem_sel && prev_page[15:3] == 13'h001D |-> pins_gpio[10:6] == 5'h1F
                         && pins_gpio[4] && pins_gpio[1:0] == 2'h3) else $error("shared window went external");
    a_port1_block:
        assert property (port1_addr_inhibit == (pins_gpio[9:6] != 4'hF)) else $error("port1 inhibit wrong");
    a_clk_exempt:
        assert property (unit_clk_en[2] && unit_clk_en[3] && unit_clk_en[10]) else $error("exempt clock gated");
    a_one_target:
        assert property (ext_mem_sel |-> unit_sel == 11'h000 && !small_ram_sel) else $error("two targets");

    c_pwm: cover property (unit_sel[6]);
    c_ext: cover property (ext_mem_sel);
    c_large: cover property (large_ram_cs);
endmodule // xpd_monitor

bind xpd_periph_enable xpd_monitor #(.ADDR_W(ADDR_W)) i_xpd_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .cpu_req(cpu_req), .cpu_addr(cpu_addr), .unit_sel(unit_sel), .small_ram_sel(small_ram_sel),
    .large_ram_cs(large_ram_cs), .ext_mem_sel(ext_mem_sel), .pins_gpio(pins_gpio),
    .port1_addr_inhibit(port1_addr_inhibit), .unit_clk_en(unit_clk_en));

// ---- tb_xpd_periph_enable.sv ----
`timescale 1ns/1ps
module tb_xpd_periph_enable;
    // One decode case: enable value, address, unit selects, {small, large, ext, port1}.
    typedef struct packed {
        logic [15:0] en;
        logic [23:0] addr;
        logic [10:0] sel;
        logic [3:0]  flags;
    } xpd_row_t;

    reg           pclk, presetn, psel, penable, pwrite, emu_mode_pin, eoi;
    reg  [7:0]    paddr;
    reg  [31:0]   pwdata;
    wire          pready, pslverr, small_ram_sel, large_ram_cs, ext_mem_sel, port1_addr_inhibit, cpu_req;
    wire [31:0]   prdata;
    wire [23:0]   cpu_addr;
    wire [10:0]   unit_sel, pins_gpio, unit_clk_en;
    wire [15:0]   mirror_value;
    wire [63:0]   emu_regs_flat;
    integer       miscompares, cmp_count, i;
    reg  [31:0]   rd;
    reg           err;
    xpd_row_t     rows [0:11];

    xpd_periph_enable i_xpd_periph_enable (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .emu_mode_pin(emu_mode_pin), .end_of_init_instruction(eoi), .cpu_req(cpu_req),
        .cpu_addr(cpu_addr), .unit_sel(unit_sel), .small_ram_sel(small_ram_sel),
        .large_ram_cs(large_ram_cs), .ext_mem_sel(ext_mem_sel), .pins_gpio(pins_gpio),
        .port1_addr_inhibit(port1_addr_inhibit), .unit_clk_en(unit_clk_en),
        .mirror_value(mirror_value), .emu_regs_flat(emu_regs_flat));
    xpd_cpu_model i_xpd_cpu_model (.pclk(pclk), .cpu_req(cpu_req), .cpu_addr(cpu_addr));

    // Free-running 40 MHz bus clock.
    always #12.5 pclk = ~pclk;

    // Compares one value; four-state so an unknown never matches.
    task check(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // One APB transfer; waits for pready rather than assuming the slave is zero-wait.
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0; penable <= 1'b0;
        end
    endtask

    task rdchk(input [7:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0000_0000);
            check(rd, exp);
        end
    endtask

    // Low for three cycles; also reopens the enable register after a lock.
    task apply_reset;
        begin
            @(posedge pclk);
            presetn <= 1'b0;
            repeat (3) @(posedge pclk);
            presetn <= 1'b1;
        end
    endtask

    // The single exit point: counts, then the verdict.
    task report_and_stop;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
            if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask

    // Guards against a hung handshake; the whole run needs well under this span.
    initial begin
        #(25 * 6000);
        miscompares = miscompares + 1;
        report_and_stop;
    end

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; emu_mode_pin = 0; eoi = 0;
        paddr = 8'h00; pwdata = 32'h0000_0000; miscompares = 0; cmp_count = 0;
        rows[0]  = {16'h0040, 24'h00EC10, 11'h040, 4'h1};
        rows[1]  = {16'h0010, 24'h00ED20, 11'h010, 4'h0};
        rows[2]  = {16'h0000, 24'h00EA00, 11'h000, 4'h2};
        rows[3]  = {16'h0010, 24'h00EC10, 11'h000, 4'h0};
        rows[4]  = {16'h0001, 24'h00EF00, 11'h001, 4'h0};
        rows[5]  = {16'h0002, 24'h00EE00, 11'h002, 4'h0};
        rows[6]  = {16'h0000, 24'h00E100, 11'h000, 4'h2};
        rows[7]  = {16'h0004, 24'h00E100, 11'h000, 4'h8};
        rows[8]  = {16'h0780, 24'h00EB00, 11'h400, 4'h1};
        rows[9]  = {16'h0008, 24'h0F0000, 11'h000, 4'h4};
        rows[10] = {16'h0000, 24'h0F0000, 11'h000, 4'h2};
        rows[11] = {16'h0100, 24'h00E800, 11'h100, 4'h1};
        // Each row: fresh reset, program enables, set global enable, one access.
        for (i = 0; i < 12; i = i + 1) begin
            apply_reset;
            apb(1'b1, 8'h00, {16'h0000, rows[i].en});
            apb(1'b1, 8'h18, 32'h0000_0004);
            repeat (2) @(posedge pclk);
            i_xpd_cpu_model.access(rows[i].addr);
            #1;
            check({21'h0, unit_sel}, {21'h0, rows[i].sel});
            check({28'h0, small_ram_sel, large_ram_cs, ext_mem_sel, port1_addr_inhibit},
                  {28'h0, rows[i].flags});
            check({21'h0, pins_gpio}, {21'h0, ~rows[i].en[10:0]});
        end
        // Reset values, then the locking order that software follows.
        apply_reset;
        rdchk(8'h00, 32'h0000_0005);
        rdchk(8'h1C, 32'h0000_800B);
        apb(1'b1, 8'h00, 32'h0000_0041);
        apb(1'b1, 8'h18, 32'h0000_0004);
        apb(1'b1, 8'h04, 32'h0000_0041);
        // Copies reach the outputs one registered stage after the write.
        repeat (2) @(posedge pclk);
        check({16'h0, mirror_value}, 32'h0000_0041);
        rdchk(8'h04, 32'h0000_0000);
        apb(1'b1, 8'h08, 32'h0000_1234);
        apb(1'b1, 8'h14, 32'h0000_5678);
        repeat (2) @(posedge pclk);
        check(emu_regs_flat[31:0], 32'h0000_1234);
        check(emu_regs_flat[63:32], 32'h5678_0000);
        rdchk(8'h08, 32'h0000_0000);
        apb(1'b1, 8'h00, 32'h0000_0000);
        rdchk(8'h00, 32'h0000_0041);
        apb(1'b1, 8'h1C, 32'h0000_0806);
        rdchk(8'h1C, 32'h0000_0806);
        // After end of init the range register freezes and idle peripherals other than misc lose their clock.
        @(posedge pclk);
        eoi <= 1'b1;
        @(posedge pclk);
        eoi <= 1'b0;
        apb(1'b1, 8'h1C, 32'h0000_F006);
        rdchk(8'h1C, 32'h0000_0806);
        check({21'h0, unit_clk_en}, 32'h0000_044D);
        // The mode pin passes a two-stage synchroniser, so give it a few cycles.
        emu_mode_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        rdchk(8'h00, 32'h0000_FFFF);
        rdchk(8'h20, 32'h0000_0007);
        apb(1'b0, 8'h24, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        report_and_stop;
    end
endmodule // tb_xpd_periph_enable
